/* File: controller_model.sv */
// Controller stand-in: supplies the speed limit word of each safety cycle.
// Assumes safety_cycle pulses from the bench on the shared sys_clk.
`timescale 1ns/1ns
module controller_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        safety_cycle,
  output logic [15:0]      speed_limit_value_out
);
  // Walks the legal range with both ends, never 0
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_limit_value_out <= 16'h0001;
    end else if (safety_cycle) begin
      if (speed_limit_value_out == 16'h7FFF) speed_limit_value_out <= 16'h0001;
      else if (speed_limit_value_out > 16'h6000) speed_limit_value_out <= 16'h7FFF;
      else speed_limit_value_out <= speed_limit_value_out + 16'h1FFF;
    end
  end
endmodule : controller_model

/* File: divide_if.sv */
// Request and answer of the position scaling divider.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface divide_if;
  logic        start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        busy;
  logic        done;
  logic [31:0] quotient;
  modport requester (output start, output dividend, output divisor,
                     input busy, input done, input quotient);
  modport divider   (input start, input dividend, input divisor,
                     output busy, output done, output quotient);
endinterface : divide_if

/* File: position_divider.sv */
// Serial signed-by-unsigned divider, quotient truncated toward zero.
// Assumes start is raised only while busy is low; a zero divisor acts as one.
`timescale 1ns/1ns
`include "telegram_params.svh"
module position_divider
  import telegram_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  divide_if.divider dv
);
  logic [31:0] quot_q;
  logic [16:0] rem_q;
  logic [15:0] div_q;
  logic        neg_q;
  logic [5:0]  steps_q;
  logic        busy_q;
  logic        done_q;
  logic [16:0] rem_sh;

  assign rem_sh      = {rem_q[15:0], quot_q[31]};
  assign dv.busy     = busy_q;
  assign dv.done     = done_q;
  // Fraction dropped by dividing the magnitude, then restoring sign
  assign dv.quotient = neg_q ? (32'h0000_0000 - quot_q) : quot_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      quot_q  <= 32'h0000_0000;
      rem_q   <= 17'h0_0000;
      div_q   <= 16'h0001;
      neg_q   <= 1'b0;
      steps_q <= 6'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (dv.start && !busy_q) begin
        quot_q  <= dv.dividend[31] ? (32'h0000_0000 - dv.dividend) : dv.dividend;
        neg_q   <= dv.dividend[31];
        div_q   <= (dv.divisor == 16'h0000) ? 16'h0001 : dv.divisor;
        rem_q   <= 17'h0_0000;
        steps_q <= `DIV_STEPS;
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        if (rem_sh >= {1'b0, div_q}) begin
          rem_q  <= rem_sh - {1'b0, div_q};
          quot_q <= {quot_q[30:0], 1'b1};
        end else begin
          rem_q  <= rem_sh;
          quot_q <= {quot_q[30:0], 1'b0};
        end
        steps_q <= steps_q - 6'h01;
        if (steps_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : position_divider

/* File: safety_status_telegram_words.sv */
// Builds status bytes two and three and the extra cyclic words of both telegrams.
// Assumes one safety cycle pulse per bus cycle and monitoring flags synchronous to sys_clk.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "telegram_params.svh"

module safety_status_telegram_words
  import telegram_pkg::*;
#(
  parameter bit FAILSAFE_INPUTS_PRESENT = 1'b1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         safety_cycle,
  input  wire logic         area_two_active,
  input  wire logic         position_valid,
  input  wire logic         safely_referenced,
  input  wire logic [2:0]   failsafe_input,
  input  wire logic         extended_stop_two,
  input  wire logic         safe_operating_stop,
  input  wire logic         upper_limit_held,
  input  wire logic         lower_limit_held,
  input  wire logic [31:0]  safe_position,
  input  wire logic [15:0]  active_speed_limit,
  input  wire logic [15:0]  speed_limit_value_out,
  input  wire reg_addr_t    reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [31:0]       reg_rdata,
  output status_byte_t      status_byte_two,
  output status_byte_t      status_byte_three,
  output tele_word_t        process_word_three,
  output tele_word_t        process_word_four,
  output tele_word_t        process_word_five,
  output tele_word_t        process_word_six,
  output logic [15:0]       speed_limit_request
);
  logic [31:0]  control_q;
  logic [15:0]  scale_q;
  logic [15:0]  count_q;
  logic [31:0]  reg_rdata_q;
  status_byte_t byte_two_q;
  status_byte_t byte_three_q;
  tele_word_t   word_three_q;
  tele_word_t   word_four_q;
  tele_word_t   word_five_q;
  tele_word_t   word_six_q;
  tele_word_t   short_pos_q;
  logic [15:0]  limit_req_q;
  status_byte_t byte_two_d;
  status_byte_t byte_three_d;
  logic [31:0]  long_pos_d;
  tele_word_t   short_pos_d;
  logic         long_tele;
  logic         pos_xfer;

  // Short bounds cut to word width once, not at each use
  localparam tele_word_t SHORT_WORD_MAX = tele_word_t'(`SHORT_POS_MAX);
  localparam tele_word_t SHORT_WORD_MIN = tele_word_t'(`SHORT_POS_MIN);

  divide_if dv ();

  // One divider serves every cycle; it needs the gap between pulses
  position_divider position_divider_inst (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .dv      (dv)
  );

  assign long_tele = control_q[`CTRL_LONG_TELEGRAM];
  assign pos_xfer  = control_q[`CTRL_POSITION_XFER];

  // Status bytes; unlisted bits stay zero
  // Flags share sys_clk, so no synchroniser in front
  always_comb begin
    byte_two_d                  = 8'h00;
    byte_two_d[`SB2_AREA_TWO]   = area_two_active;
    byte_two_d[`SB2_POS_VALID]  = position_valid;
    byte_two_d[`SB2_REFERENCED] = safely_referenced;
    byte_three_d                    = 8'h00;
    if (FAILSAFE_INPUTS_PRESENT) begin
      byte_three_d[`SB3_FSI_LOW +: 3] = ~failsafe_input;
    end
    byte_three_d[`SB3_EXT_STOP_TWO] = extended_stop_two;
    byte_three_d[`SB3_SAFE_OP_STOP] = safe_operating_stop;
    byte_three_d[`SB3_UPPER_HELD]   = upper_limit_held;
    byte_three_d[`SB3_LOWER_HELD]   = lower_limit_held;
  end

  // Clamp long position, saturate scaled short position
  always_comb begin
    // Long word carries the position unscaled
    if ($signed(safe_position) > $signed(`LONG_POS_MAX)) begin
      long_pos_d = `LONG_POS_MAX;
    end else if ($signed(safe_position) < $signed(`LONG_POS_MIN)) begin
      long_pos_d = `LONG_POS_MIN;
    end else begin
      long_pos_d = safe_position;
    end
    // Guards against a badly chosen scale factor
    if ($signed(dv.quotient) > $signed(`SHORT_POS_MAX)) begin
      short_pos_d = SHORT_WORD_MAX;
    end else if ($signed(dv.quotient) < $signed(`SHORT_POS_MIN)) begin
      short_pos_d = SHORT_WORD_MIN;
    end else begin
      short_pos_d = dv.quotient[15:0];
    end
  end

  // A pulse while the divider is busy is ignored; zero scale acts as one
  assign dv.start    = safety_cycle;
  assign dv.dividend = safe_position;
  assign dv.divisor  = scale_q;

  // Software registers
  // Status, count and position are read-only; writes there are dropped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_q <= `CONTROL_RESET;
      scale_q   <= `SCALE_RESET;
    end else if (reg_write) begin
      if (reg_addr == `REG_CONTROL) begin
        control_q <= reg_wdata;
      end
      if (reg_addr == `REG_SCALE) begin
        scale_q <= reg_wdata[15:0];
      end
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  // Narrow registers sit in the low bits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `REG_CONTROL:     reg_rdata_q <= control_q;
        `REG_SCALE:       reg_rdata_q <= {16'h0000, scale_q};
        `REG_STATUS:      reg_rdata_q <= {16'h0000, byte_three_q, byte_two_q};
        `REG_CYCLE_COUNT: reg_rdata_q <= {16'h0000, count_q};
        `REG_POSITION:    reg_rdata_q <= {16'h0000, short_pos_q};
        default:          reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // Safety cycle counter, wraps through the full 16-bit range
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 16'h0000;
    end else if (safety_cycle) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Scaled position lands when the divider finishes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      short_pos_q <= 16'h0000;
    end else if (dv.done) begin
      short_pos_q <= short_pos_d;
    end
  end

  // Telegram words refresh once per safety cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_two_q   <= 8'h00;
      byte_three_q <= 8'h00;
      word_three_q <= 16'h0000;
      word_four_q  <= 16'h0000;
      word_five_q  <= 16'h0000;
      word_six_q   <= 16'h0000;
      limit_req_q  <= 16'h0000;
    end else if (safety_cycle) begin
      byte_two_q   <= byte_two_d;
      byte_three_q <= byte_three_d;
      limit_req_q  <= speed_limit_value_out;
      // Controller ignores this unless level one and bit 24 say otherwise
      word_three_q <= control_q[`CTRL_LIMIT_XFER] ? active_speed_limit : 16'h0000;
      // Count before its increment, so the first pulse sends zero
      word_four_q  <= count_q;
      if (!pos_xfer) begin
        word_five_q <= 16'h0000;
        word_six_q  <= 16'h0000;
      end else if (long_tele) begin
        word_five_q <= long_pos_d[31:16];
        word_six_q  <= long_pos_d[15:0];
      end else begin
        // Short word lags one cycle: divider needs 33 clocks
        word_five_q <= short_pos_q;
        word_six_q  <= 16'h0000;
      end
    end
  end

  assign reg_rdata           = reg_rdata_q;
  assign status_byte_two     = byte_two_q;
  assign status_byte_three   = byte_three_q;
  assign process_word_three  = word_three_q;
  assign process_word_four   = word_four_q;
  assign process_word_five   = word_five_q;
  assign process_word_six    = word_six_q;
  assign speed_limit_request = limit_req_q;
endmodule : safety_status_telegram_words

/* File: safety_status_telegram_words_tb.sv */
// Self-checking bench for the telegram word builder.
// Assumes pulses at least 40 cycles apart, well above the divider's 33.
`timescale 1ns/1ns
`include "telegram_params.svh"
module safety_status_telegram_words_tb
  import telegram_pkg::*;
;
  typedef struct packed {status_byte_t b2; status_byte_t b3; tele_word_t w3, w4, w5, w6, req;} tele_s;
  logic         sys_clk = 1'b0, reset_n = 1'b0, safety_cycle = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic         seen_q = 1'b0, rd_q = 1'b0;
  logic [9:0]   flags = '0;
  logic [31:0]  safe_position = '0, reg_wdata = '0, reg_rdata, rnd = 32'h0000_3F02, ctrl_m = '0;
  logic [15:0]  active_speed_limit = '0, speed_limit_value_out, slr, scale_m = 16'h0001;
  tele_word_t   w3, w4, w5, w6, cnt = '0;
  status_byte_t sb2, sb3;
  reg_addr_t    reg_addr = '0;
  int           errors = 0, cmp_count = 0, cyc = 0, short_prev = 0, lp;
  tele_s        e, m;
  tele_s        tq[$];
  logic [31:0]  rq[$];
  logic [31:0]  ctl [6] = '{32'h0300_0000, 32'h0300_0000, 32'h0300_0000, 32'h0300_0001, 32'h0300_0001, 32'h0000_0000};
  logic [15:0]  scl [6] = '{16'h03E8, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0007};
  logic [31:0]  pos [6] = '{32'hFFFF_8AD1, 32'h0001_86A0, 32'hFFFE_7960, 32'h7FFF_FFFF, 32'h8000_0000, 32'h0012_3456};

  safety_status_telegram_words safety_status_telegram_words_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .safety_cycle(safety_cycle), .area_two_active(flags[0]), .position_valid(flags[1]),
    .safely_referenced(flags[2]), .failsafe_input(flags[5:3]), .extended_stop_two(flags[6]),
    .safe_operating_stop(flags[7]), .upper_limit_held(flags[8]), .lower_limit_held(flags[9]),
    .safe_position(safe_position), .active_speed_limit(active_speed_limit),
    .speed_limit_value_out(speed_limit_value_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .status_byte_two(sb2),
    .status_byte_three(sb3), .process_word_three(w3), .process_word_four(w4), .process_word_five(w5),
    .process_word_six(w6), .speed_limit_request(slr));
  controller_model controller_model_inst (.sys_clk(sys_clk), .reset_n(reset_n), .safety_cycle(safety_cycle),
    .speed_limit_value_out(speed_limit_value_out));

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic int clamp(input int v, input int lim);
    return (v > lim) ? lim : (v < -lim) ? -lim : v;
  endfunction : clamp

  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk16(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t word got %h expected %h", $time, g, x);
    end
  endtask : chk16
  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t read got %h expected %h", $time, g, x);
    end
  endtask : chk32
  task automatic wr(input reg_addr_t a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input reg_addr_t a, input logic [31:0] x);
    rq.push_back(x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask : rd
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      rnd = xs(rnd);
      flags <= rnd[9:0];
      active_speed_limit <= rnd[31:16];
      @(posedge sys_clk);
      safety_cycle <= 1'b1;
      @(posedge sys_clk);
      safety_cycle <= 1'b0;
      repeat (37) @(posedge sys_clk);
    end
  endtask : pulse

  // Notes what the words must carry after each pulse
  always @(posedge sys_clk) begin
    seen_q <= reset_n && safety_cycle;
    rd_q <= reg_read;
    if (reset_n && safety_cycle === 1'b1) begin
      lp = clamp($signed(safe_position), 737280000);
      e.b2 = {flags[2], flags[1], 2'b00, flags[0], 3'b000};
      e.b3 = {flags[9:6], 1'b0, ~flags[5:3]};
      e.w3 = ctrl_m[24] ? active_speed_limit : 16'h0000;
      e.w4 = cnt;
      e.w5 = !ctrl_m[25] ? 16'h0000 : ctrl_m[0] ? lp[31:16] : short_prev[15:0];
      e.w6 = (ctrl_m[25] && ctrl_m[0]) ? lp[15:0] : 16'h0000;
      e.req = speed_limit_value_out;
      tq.push_back(e);
      cnt++;
      short_prev = clamp($signed(safe_position) / int'(scale_m), 32767);
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
    if (seen_q) begin
      m = tq.pop_front();
      chk16({8'h00, sb2}, {8'h00, m.b2});
      chk16({8'h00, sb3}, {8'h00, m.b3});
      chk16(w3, m.w3);
      chk16(w4, m.w4);
      chk16(w5, m.w5);
      chk16(w6, m.w6);
      chk16(slr, m.req);
    end
    if (rd_q) chk32(reg_rdata, rq.pop_front());
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`REG_CONTROL, `CONTROL_RESET);
    rd(`REG_SCALE, {16'h0000, `SCALE_RESET});
    rd(8'h40, 32'h0000_0000);
    // Read-only status must ignore the write
    wr(`REG_STATUS, 32'hFFFF_FFFF);
    rd(`REG_STATUS, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      ctrl_m = ctl[i];
      scale_m = scl[i];
      wr(`REG_CONTROL, ctrl_m);
      wr(`REG_SCALE, {16'h0000, scale_m});
      safe_position <= pos[i];
      pulse(3);
    end
    rd(`REG_STATUS, {16'h0000, e.b3, e.b2});
    rd(`REG_CONTROL, ctrl_m);
    rd(`REG_CYCLE_COUNT, {16'h0000, cnt});
    rd(`REG_POSITION, {16'h0000, short_prev[15:0]});
    repeat (3) @(posedge sys_clk);
    conclude();
  end
endmodule : safety_status_telegram_words_tb

/* File: telegram_params.svh */
// Constants for the safety telegram word builder.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TELEGRAM_PARAMS_SVH
`define TELEGRAM_PARAMS_SVH

// Register byte addresses
`define REG_CONTROL       8'h00
`define REG_SCALE         8'h04
`define REG_STATUS        8'h08
`define REG_CYCLE_COUNT   8'h0C
`define REG_POSITION      8'h10

// Control register fields
`define CTRL_LONG_TELEGRAM 0
`define CTRL_LIMIT_XFER    24
`define CTRL_POSITION_XFER 25

// Reset values
`define CONTROL_RESET 32'h0000_0000
`define SCALE_RESET   16'h0001

// Status byte two bit positions
`define SB2_AREA_TWO     3
`define SB2_POS_VALID    6
`define SB2_REFERENCED   7
// Status byte three bit positions
`define SB3_FSI_LOW      0
`define SB3_EXT_STOP_TWO 4
`define SB3_SAFE_OP_STOP 5
`define SB3_UPPER_HELD   6
`define SB3_LOWER_HELD   7

// Value limits
`define SHORT_POS_MAX   32'h0000_7FFF
`define SHORT_POS_MIN   32'hFFFF_8001
`define LONG_POS_MAX    32'h2BF2_0000
`define LONG_POS_MIN    32'hD40E_0000

// Divider iteration count
`define DIV_STEPS       6'h20

`endif

/* File: telegram_pkg.sv */
// Types shared by the telegram word builder and its divider.
// Assumes telegram_params.svh is reachable on the include path.
`include "telegram_params.svh"
package telegram_pkg;
  typedef logic [7:0]  status_byte_t;
  typedef logic [15:0] tele_word_t;
  typedef logic [7:0]  reg_addr_t;
endpackage : telegram_pkg

/* File: telegram_words_chk.sv */
// Checker for the status bytes, telegram words four and five and the speed limit request of the framer.
// Assumes one clock, sys_clk, and the active-low reset_n; sees top ports only.
`timescale 1ns/1ns
module telegram_words_chk
  import telegram_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         reset_n,
  input wire logic         safety_cycle,
  input wire logic         area_two_active,
  input wire logic         position_valid,
  input wire logic         safely_referenced,
  input wire logic [2:0]   failsafe_input,
  input wire logic         extended_stop_two,
  input wire logic         safe_operating_stop,
  input wire logic         upper_limit_held,
  input wire logic         lower_limit_held,
  input wire logic [15:0]  speed_limit_value_out,
  input wire status_byte_t status_byte_two,
  input wire status_byte_t status_byte_three,
  input wire tele_word_t   process_word_four,
  input wire tele_word_t   process_word_five,
  input wire logic [15:0]  speed_limit_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_area_two_bit: assert property ($past(safety_cycle) |-> status_byte_two[3] == $past(area_two_active))
    else $error("area bit wrong");
  a_pos_flag_bits: assert property ($past(safety_cycle) |->
    status_byte_two[7:6] == {$past(safely_referenced), $past(position_valid)})
    else $error("position flag bits wrong");
  a_inputs_inverted: assert property ($past(safety_cycle) |->
    status_byte_three[2:0] == ~$past(failsafe_input))
    else $error("failsafe input bits wrong");
  a_stop_bits: assert property ($past(safety_cycle) |->
    status_byte_three[6:4] == {$past(upper_limit_held), $past(safe_operating_stop), $past(extended_stop_two)})
    else $error("stop bits wrong");
  a_lower_held_bit: assert property ($past(safety_cycle) |-> status_byte_three[7] == $past(lower_limit_held))
    else $error("lower limit bit wrong");
  a_reserved_zero: assert property ((status_byte_two & 8'h37) == 8'h00 && !status_byte_three[3])
    else $error("reserved bit set");
  // Words may only move on the edge after a pulse
  a_words_hold: assert property (!$past(safety_cycle) |->
    $stable(process_word_four) && $stable(process_word_five))
    else $error("telegram word moved between pulses");
  a_limit_echo: assert property ($past(safety_cycle) |-> speed_limit_request == $past(speed_limit_value_out))
    else $error("speed limit request wrong");
  c_pulse: cover property (safety_cycle);
  c_area_two: cover property (safety_cycle && area_two_active);
  c_inputs_all: cover property (safety_cycle && failsafe_input == 3'b111);
endmodule : telegram_words_chk

bind safety_status_telegram_words telegram_words_chk telegram_words_chk_inst (.sys_clk, .reset_n, .safety_cycle,
  .area_two_active, .position_valid, .safely_referenced, .failsafe_input, .extended_stop_two, .safe_operating_stop,
  .upper_limit_held, .lower_limit_held, .speed_limit_value_out, .status_byte_two, .status_byte_three,
  .process_word_four, .process_word_five, .speed_limit_request);
